// ---- fieldbus_master_model.sv ----
`default_nettype none
module fieldbus_master_model (
  input wire logic clk_sys, // system clock
  input wire logic req, // issue one sync event
  input wire logic good, // cyclic data refreshed with it
  output logic sync_event, // sync pulse to the drive
  output logic pdo_updated // refresh flag, meaningful with sync only
);
  timeunit 1ns;
  timeprecision 1ps;
  logic junk_reg = 1'b0;
  // flag wanders between events so a drive sampling it off-event is caught
  always @(posedge clk_sys) begin
    junk_reg <= ~junk_reg;
  end
  // cycle objects untouched here, drive keeps its initial cycle
  assign sync_event = req;
  assign pdo_updated = req ? good : junk_reg;
endmodule
`default_nettype wire

// ---- network_cycle_sync_supervisor.sv ----
`default_nettype none
module network_cycle_sync_supervisor (
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic init_req, // initialisation strobe
  input wire logic sync_event, // sync event pulse
  input wire logic pdo_updated, // cyclic data refreshed this cycle
  input wire logic alarm_reset, // clears receive error alarm
  input wire logic param_wr, // parameter write strobe
  input wire logic param_rd, // parameter read strobe
  input wire logic [7:0] param_idx, // parameter number
  input wire logic [31:0] param_wdata, // parameter write data
  output logic [31:0] param_rdata, // parameter read data
  output logic param_rvalid, // read answer valid
  output logic param_rerr, // unknown parameter number
  input wire logic obj_wr, // object write strobe
  input wire logic obj_rd, // object read strobe
  input wire logic [15:0] obj_index, // object index
  input wire logic [7:0] obj_sub, // object subindex
  input wire logic [31:0] obj_wdata, // object write data
  output logic [31:0] obj_rdata, // object read data
  output logic obj_rvalid, // object answer valid
  output logic obj_rerr, // unknown object
  input wire logic [31:0] warn_active_raw, // active warning details
  input wire logic [31:0] warn_latched_raw, // latched warning details
  input wire logic [31:0] err_active_raw, // active error details
  input wire logic [31:0] err_latched_raw, // latched error details
  output logic [31:0] warn_active_masked, // filtered active warnings
  output logic [31:0] warn_latched_masked, // filtered latched warnings
  output logic [31:0] err_active_masked, // filtered active errors
  output logic [31:0] err_latched_masked, // filtered latched errors
  output logic [31:0] cycle_time_out, // output sync cycle time, ns
  output logic [31:0] cycle_time_in, // input sync cycle time, ns
  output logic [9:0] map_attr, // mapping attributes, 2 bits each
  output logic parameter_error_alarm, // unsupported cycle code
  output logic network_receive_error_alarm, // sync error threshold hit
  output logic [15:0] sync_error_count // internal error counter
);
  import sync_supervisor_pkg::*;

  localparam top_s top_rst = '{
    mode: mode_rst,
    cycle: cycle_rst,
    limit: limit_rst,
    warn_mask: mask_rst,
    err_mask: mask_rst,
    cyc_out: cyc_ns_250,
    cyc_in: cyc_ns_250,
    warn_act: 32'h00000000,
    warn_lat: 32'h00000000,
    err_act: 32'h00000000,
    err_lat: 32'h00000000,
    prdata: 32'h00000000,
    prvalid: 1'b0,
    prerr: 1'b0,
    ordata: 32'h00000000,
    orvalid: 1'b0,
    orerr: 1'b0,
    par_alarm: 1'b0,
    map_attr: {5{map_rx}}
  };

  top_s st_reg;
  top_s st_next;
  logic cyc_ok;
  logic [31:0] cyc_ns;
  logic attr_old;
  logic [23:0] okey;

  assign okey = {obj_index, obj_sub};

  always_comb begin
    cyc_ok = 1'b1;
    cyc_ns = cyc_ns_250;
    case (st_reg.cycle)
      cyc_code_auto: cyc_ns = cyc_ns_250;
      cyc_code_125: cyc_ns = cyc_ns_125;
      cyc_code_250: cyc_ns = cyc_ns_250;
      cyc_code_500: cyc_ns = cyc_ns_500;
      cyc_code_1m: cyc_ns = cyc_ns_1m;
      cyc_code_2m: cyc_ns = cyc_ns_2m;
      cyc_code_4m: cyc_ns = cyc_ns_4m;
      cyc_code_8m: cyc_ns = cyc_ns_8m;
      default: cyc_ok = 1'b0;
    endcase
  end

  // next state of settings, mirrors and answers
  always_comb begin
    st_next = st_reg;
    st_next.par_alarm = !cyc_ok;

    attr_old = (st_reg.mode[attr_msb:attr_lsb] == attr_sel_old);
    if (attr_old) begin
      st_next.map_attr = {map_both, map_tx, map_tx, map_tx, map_tx};
    end else begin
      st_next.map_attr = {5{map_rx}};
    end

    st_next.warn_act = warn_active_raw & st_reg.warn_mask;
    st_next.warn_lat = warn_latched_raw & st_reg.warn_mask;
    st_next.err_act = err_active_raw & st_reg.err_mask;
    st_next.err_lat = err_latched_raw & st_reg.err_mask;

    // initial cycle copied at init; bad codes leave objects alone
    if (init_req && cyc_ok) begin
      // zero code decodes to 250000 ns
      st_next.cyc_out = cyc_ns;
      st_next.cyc_in = cyc_ns;
    end

    // parameter writes
    if (param_wr) begin
      case (param_idx)
        pidx_mode: st_next.mode = param_wdata;
        pidx_cycle: st_next.cycle = param_wdata;
        pidx_limit: begin
          if (param_wdata <= {16'h0000, limit_max}) begin
            st_next.limit = param_wdata[15:0];
          end
        end
        pidx_warn: st_next.warn_mask = param_wdata;
        pidx_err: st_next.err_mask = param_wdata;
        default: st_next.mode = st_next.mode;
      endcase
    end

    // object writes come later so the network side wins a same-cycle clash
    if (obj_wr) begin
      case (okey)
        okey_cycle_out: st_next.cyc_out = obj_wdata;
        okey_cycle_in: st_next.cyc_in = obj_wdata;
        okey_limit: begin
          // limit object shares the threshold register
          if (obj_wdata <= {16'h0000, limit_max}) begin
            st_next.limit = obj_wdata[15:0];
          end
        end
        // warning mask object shares the register
        okey_warn_mask: st_next.warn_mask = obj_wdata;
        // error mask object shares the register
        okey_err_mask: st_next.err_mask = obj_wdata;
        default: st_next.cyc_out = st_next.cyc_out;
      endcase
    end

    // parameter read answer, one cycle after the strobe
    st_next.prvalid = param_rd;
    st_next.prerr = 1'b0;
    st_next.prdata = 32'h00000000;
    if (param_rd) begin
      case (param_idx)
        pidx_mode: st_next.prdata = st_reg.mode;
        pidx_cycle: st_next.prdata = st_reg.cycle;
        pidx_limit: st_next.prdata = {16'h0000, st_reg.limit};
        pidx_warn: st_next.prdata = st_reg.warn_mask;
        pidx_err: st_next.prdata = st_reg.err_mask;
        default: st_next.prerr = 1'b1;
      endcase
    end

    // object read answer, one cycle after the strobe
    st_next.orvalid = obj_rd;
    st_next.orerr = 1'b0;
    st_next.ordata = 32'h00000000;
    if (obj_rd) begin
      case (okey)
        okey_cycle_out: st_next.ordata = st_reg.cyc_out;
        okey_cycle_in: st_next.ordata = st_reg.cyc_in;
        okey_limit: st_next.ordata = {16'h0000, st_reg.limit};
        okey_warn_mask: st_next.ordata = st_reg.warn_mask;
        okey_err_mask: st_next.ordata = st_reg.err_mask;
        okey_warn_act: st_next.ordata = st_reg.warn_act;
        okey_warn_lat: st_next.ordata = st_reg.warn_lat;
        okey_err_act: st_next.ordata = st_reg.err_act;
        okey_err_lat: st_next.ordata = st_reg.err_lat;
        default: st_next.orerr = 1'b1;
      endcase
    end
  end

  // state register; clk_en low freezes everything
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= top_rst;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // sync error supervision, kept apart so the counter can be reused per axis
  sync_error_counter u_counter (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .sync_event(sync_event),
    .pdo_updated(pdo_updated),
    .alarm_reset(alarm_reset),
    .limit(st_reg.limit),
    .count(sync_error_count),
    .tripped(network_receive_error_alarm)
  );

  // outputs straight from state flops
  assign param_rdata = st_reg.prdata;
  assign param_rvalid = st_reg.prvalid;
  assign param_rerr = st_reg.prerr;
  assign obj_rdata = st_reg.ordata;
  assign obj_rvalid = st_reg.orvalid;
  assign obj_rerr = st_reg.orerr;
  assign warn_active_masked = st_reg.warn_act;
  assign warn_latched_masked = st_reg.warn_lat;
  assign err_active_masked = st_reg.err_act;
  assign err_latched_masked = st_reg.err_lat;
  assign cycle_time_out = st_reg.cyc_out;
  assign cycle_time_in = st_reg.cyc_in;
  assign map_attr = st_reg.map_attr;
  assign parameter_error_alarm = st_reg.par_alarm;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_init_copies_cycle: assert property (clk_en && init_req && cyc_ok && !obj_wr
    |=> cycle_time_out == $past(cyc_ns) && cycle_time_in == $past(cyc_ns))
    else $error("initial cycle not copied");

  a_zero_gives_250us: assert property (clk_en && init_req && !obj_wr
    && st_reg.cycle == 32'h00000000 |=> cycle_time_out == 32'h0003d090
    && cycle_time_in == 32'h0003d090)
    else $error("zero code did not load 250000 ns");

  a_decode_fast: assert property (clk_en && init_req && !obj_wr
    && st_reg.cycle == 32'h00000004 |=> cycle_time_out == 32'h0001e848)
    else $error("125 us code decoded wrong");

  a_decode_slow: assert property (clk_en && init_req && !obj_wr
    && st_reg.cycle == 32'h0000000a |=> cycle_time_out == 32'h007a1200
    && cycle_time_in == 32'h007a1200)
    else $error("8 ms code decoded wrong");

  a_bad_code_alarm: assert property (clk_en && st_reg.cycle > 32'h0000000a
    |=> parameter_error_alarm)
    else $error("unsupported cycle code without alarm");

  a_gap_code_alarm: assert property (clk_en && st_reg.cycle != 32'h00000000
    && st_reg.cycle < 32'h00000004 |=> parameter_error_alarm)
    else $error("gap cycle code without alarm");

  a_good_code_quiet: assert property (clk_en && (st_reg.cycle == 32'h00000000
    || (st_reg.cycle >= 32'h00000004 && st_reg.cycle <= 32'h0000000a))
    |=> !parameter_error_alarm)
    else $error("supported cycle code raised alarm");

  a_bad_code_keeps: assert property (clk_en && init_req && !obj_wr
    && (st_reg.cycle > 32'h0000000a || (st_reg.cycle != 32'h0 && st_reg.cycle < 32'h4))
    |=> $stable(cycle_time_out) && $stable(cycle_time_in))
    else $error("unsupported code changed cycle time");

  a_attr_selects: assert property (clk_en && st_reg.mode[15:12] == 4'h1
    |=> map_attr == 10'h3aa)
    else $error("older attribute set not applied");

  a_attr_newer: assert property (clk_en && st_reg.mode[15:12] == 4'h0
    |=> map_attr == 10'h155)
    else $error("newer attribute set not applied");

  a_warn_filter: assert property (clk_en
    |=> warn_active_masked == ($past(warn_active_raw) & $past(st_reg.warn_mask))
    && warn_latched_masked == ($past(warn_latched_raw) & $past(st_reg.warn_mask)))
    else $error("warning details not masked");

  a_err_filter: assert property (clk_en
    |=> err_active_masked == ($past(err_active_raw) & $past(st_reg.err_mask))
    && err_latched_masked == ($past(err_latched_raw) & $past(st_reg.err_mask)))
    else $error("error details not masked");

  a_limit_refused: assert property (clk_en && param_wr && param_idx == 8'h12
    && param_wdata > 32'h00007fff && !(obj_wr && okey == 24'h10f102)
    |=> st_reg.limit == $past(st_reg.limit))
    else $error("out-of-range threshold accepted");

  a_obj_limit_refused: assert property (clk_en && obj_wr && okey == 24'h10f102
    && obj_wdata > 32'h00007fff && !(param_wr && param_idx == 8'h12)
    |=> st_reg.limit == $past(st_reg.limit))
    else $error("out-of-range limit object accepted");

  a_limit_mirror: assert property (clk_en && obj_wr && okey == 24'h10f102
    && obj_wdata <= 32'h00007fff ##1 !param_wr && !obj_wr
    ##1 clk_en && param_rd && param_idx == 8'h12
    |=> param_rdata == $past(obj_wdata, 3))
    else $error("limit object not mirrored in threshold");

  a_warn_mirror: assert property (clk_en && param_wr && param_idx == 8'h21 && !obj_wr
    ##1 !param_wr && !obj_wr ##1 clk_en && obj_rd && okey == 24'hf3a100
    |=> obj_rdata == $past(param_wdata, 3))
    else $error("warning mask not mirrored");

  a_err_mirror: assert property (clk_en && obj_wr && okey == 24'hf3a300
    ##1 !param_wr && !obj_wr ##1 clk_en && param_rd && param_idx == 8'h22
    |=> param_rdata == $past(obj_wdata, 3))
    else $error("error mask not mirrored");

  c_init_seen: cover property (clk_en && init_req && cyc_ok);
  c_bad_code: cover property (parameter_error_alarm);
  c_rx_alarm: cover property (network_receive_error_alarm);
endmodule
`default_nettype wire

// ---- sync_error_counter.sv ----
`default_nettype none
module sync_error_counter (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic sync_event, // one pulse per sync event
  input wire logic pdo_updated, // received data was refreshed
  input wire logic alarm_reset, // clears counter and alarm
  input wire logic [15:0] limit, // threshold, zero disables
  output logic [15:0] count, // internal error counter
  output logic tripped // receive error alarm
);
  import sync_supervisor_pkg::*;

  cnt_s st_reg;
  cnt_s st_next;
  logic [15:0] base;
  logic [16:0] sum;
  cnt_state_e cur;

  // counter state machine; a clear and an event in one cycle act in that order
  always_comb begin
    st_next = st_reg;
    base = alarm_reset ? 16'h0000 : st_reg.count;
    cur = alarm_reset ? cnt_run : st_reg.state;
    sum = {1'b0, base} + {1'b0, sync_inc};
    st_next.count = base;
    st_next.state = cur;
    st_next.tripped = alarm_reset ? 1'b0 : st_reg.tripped;
    case (cur)
      cnt_off: begin
        st_next.count = 16'h0000;
        if (limit != 16'h0000) begin
          st_next.state = cnt_run;
        end
      end
      cnt_run: begin
        if (limit == 16'h0000) begin
          st_next.state = cnt_off;
          st_next.count = 16'h0000;
        end else if (sync_event) begin
          if (!pdo_updated || base >= limit) begin
            if (sum >= {1'b0, limit} || base >= limit) begin
              st_next.count = limit;
              st_next.tripped = 1'b1;
              st_next.state = cnt_trip;
            end else begin
              st_next.count = sum[15:0];
            end
          end else if (base != 16'h0000) begin
            st_next.count = base - sync_dec;
          end else begin
            st_next.count = 16'h0000;
          end
        end
      end
      cnt_trip: begin
        st_next.count = st_reg.count;
        st_next.tripped = 1'b1;
      end
      default: begin
        st_next = cnt_rst;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= cnt_rst;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
  assign tripped = st_reg.tripped;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_miss_adds_three: assert property (clk_en && sync_event && !pdo_updated && !alarm_reset
    && st_reg.state == cnt_run && limit != 16'h0000 && st_reg.count + 16'h0003 < limit
    |=> count == $past(count) + 16'h0003)
    else $error("missed update did not add three");
  a_good_subs_one: assert property (clk_en && sync_event && pdo_updated && !alarm_reset
    && st_reg.state == cnt_run && count != 16'h0000 && count < limit
    |=> count == $past(count) - 16'h0001)
    else $error("good update did not subtract one");
  a_floor_at_zero: assert property (clk_en && sync_event && pdo_updated && !alarm_reset
    && st_reg.state == cnt_run && count == 16'h0000 |=> count == 16'h0000)
    else $error("counter went below zero");
  a_trip_holds: assert property (tripped && clk_en && !alarm_reset
    |=> tripped && $stable(count))
    else $error("tripped counter moved");
  a_trip_at_limit: assert property (clk_en && !alarm_reset && st_reg.state == cnt_run
    && sync_event && !pdo_updated && limit != 16'h0000
    && {1'b0, count} + 17'h00003 >= {1'b0, limit} |=> tripped && count == $past(limit))
    else $error("threshold reached without alarm");
  a_zero_disables: assert property (limit == 16'h0000 && !tripped && clk_en
    |=> !tripped)
    else $error("alarm raised with detection disabled");
  c_trip: cover property (clk_en && !tripped ##1 tripped);
  c_recover: cover property (clk_en && sync_event && pdo_updated && count != 16'h0000);
endmodule
`default_nettype wire

// ---- sync_supervisor_dummy_guard.sv ----
`default_nettype none
`default_nettype wire

// ---- sync_supervisor_pkg.sv ----
`default_nettype none
package sync_supervisor_pkg;
  // parameter numbers used as indices on the parameter port
  localparam logic [7:0] pidx_mode = 8'h03;
  localparam logic [7:0] pidx_cycle = 8'h07;
  localparam logic [7:0] pidx_limit = 8'h12;
  localparam logic [7:0] pidx_warn = 8'h21;
  localparam logic [7:0] pidx_err = 8'h22;
  // network objects as {index, subindex}
  localparam logic [23:0] okey_cycle_out = 24'h1c3202;
  localparam logic [23:0] okey_cycle_in = 24'h1c3302;
  localparam logic [23:0] okey_limit = 24'h10f102;
  localparam logic [23:0] okey_warn_mask = 24'hf3a100;
  localparam logic [23:0] okey_err_mask = 24'hf3a300;
  localparam logic [23:0] okey_warn_act = 24'hf38100;
  localparam logic [23:0] okey_warn_lat = 24'hf39100;
  localparam logic [23:0] okey_err_act = 24'hf38300;
  localparam logic [23:0] okey_err_lat = 24'hf39300;
  // reset values
  localparam logic [31:0] mode_rst = 32'h00000000;
  localparam logic [31:0] cycle_rst = 32'h00000000;
  localparam int limit_w = 16;
  localparam logic [15:0] limit_rst = 16'h0009;
  localparam logic [15:0] limit_max = 16'h7fff;
  localparam logic [31:0] mask_rst = 32'h0fffffff;
  // object attribute selector digit in the mode word
  localparam int attr_lsb = 12;
  localparam int attr_msb = 15;
  localparam logic [3:0] attr_sel_old = 4'h1;
  // pdo mapping attribute codes {tx, rx}
  localparam logic [1:0] map_rx = 2'h1;
  localparam logic [1:0] map_tx = 2'h2;
  localparam logic [1:0] map_both = 2'h3;
  // communication cycle codes and periods in ns
  localparam logic [31:0] cyc_code_auto = 32'h00000000;
  localparam logic [31:0] cyc_code_125 = 32'h00000004;
  localparam logic [31:0] cyc_code_250 = 32'h00000005;
  localparam logic [31:0] cyc_code_500 = 32'h00000006;
  localparam logic [31:0] cyc_code_1m = 32'h00000007;
  localparam logic [31:0] cyc_code_2m = 32'h00000008;
  localparam logic [31:0] cyc_code_4m = 32'h00000009;
  localparam logic [31:0] cyc_code_8m = 32'h0000000a;
  localparam logic [31:0] cyc_ns_125 = 32'h0001e848;
  localparam logic [31:0] cyc_ns_250 = 32'h0003d090;
  localparam logic [31:0] cyc_ns_500 = 32'h0007a120;
  localparam logic [31:0] cyc_ns_1m = 32'h000f4240;
  localparam logic [31:0] cyc_ns_2m = 32'h001e8480;
  localparam logic [31:0] cyc_ns_4m = 32'h003d0900;
  localparam logic [31:0] cyc_ns_8m = 32'h007a1200;
  // sync error counter steps
  localparam logic [15:0] sync_inc = 16'h0003;
  localparam logic [15:0] sync_dec = 16'h0001;

  typedef enum logic [2:0] {
    cnt_off = 3'b001,
    cnt_run = 3'b010,
    cnt_trip = 3'b100
  } cnt_state_e;

  typedef struct packed {
    cnt_state_e state;
    logic [15:0] count;
    logic tripped;
  } cnt_s;

  localparam cnt_s cnt_rst = '{state: cnt_run, count: 16'h0000, tripped: 1'b0};

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] cycle;
    logic [15:0] limit;
    logic [31:0] warn_mask;
    logic [31:0] err_mask;
    logic [31:0] cyc_out;
    logic [31:0] cyc_in;
    logic [31:0] warn_act;
    logic [31:0] warn_lat;
    logic [31:0] err_act;
    logic [31:0] err_lat;
    logic [31:0] prdata;
    logic prvalid;
    logic prerr;
    logic [31:0] ordata;
    logic orvalid;
    logic orerr;
    logic par_alarm;
    logic [9:0] map_attr;
  } top_s;
endpackage
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sync_supervisor_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, init_req = 1'b0;
  logic req = 1'b0, good = 1'b0, alarm_reset = 1'b0;
  logic param_wr = 1'b0, param_rd = 1'b0, obj_wr = 1'b0, obj_rd = 1'b0;
  logic [7:0] param_idx = 8'h00, obj_sub = 8'h00;
  logic [15:0] obj_index = 16'h0000;
  logic [31:0] param_wdata = 32'h0, obj_wdata = 32'h0;
  logic [31:0] warn_active_raw = 32'hffffffff, warn_latched_raw = 32'h0f0f0f0f;
  logic [31:0] err_active_raw = 32'hf0f0f0f0, err_latched_raw = 32'h5a5a5a5a;
  logic sync_event, pdo_updated, param_rvalid, param_rerr, obj_rvalid, obj_rerr;
  logic parameter_error_alarm, network_receive_error_alarm;
  logic [31:0] param_rdata, obj_rdata, warn_active_masked, warn_latched_masked;
  logic [31:0] err_active_masked, err_latched_masked, cycle_time_out, cycle_time_in;
  logic [9:0] map_attr;
  logic [15:0] sync_error_count;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  logic [31:0] code_tab [8] = '{cyc_code_125, cyc_code_auto, cyc_code_250, cyc_code_500,
    cyc_code_1m, cyc_code_2m, cyc_code_4m, cyc_code_8m};
  logic [31:0] ns_tab [8] = '{cyc_ns_125, cyc_ns_250, cyc_ns_250, cyc_ns_500,
    cyc_ns_1m, cyc_ns_2m, cyc_ns_4m, cyc_ns_8m};
  logic [15:0] walk [9] = '{16'h3, 16'h2, 16'h5, 16'h4, 16'h7, 16'h6, 16'h9, 16'h9, 16'h9};

  network_cycle_sync_supervisor i_dut (.clk_sys, .rst_b, .clk_en, .init_req, .sync_event,
    .pdo_updated, .alarm_reset, .param_wr, .param_rd, .param_idx, .param_wdata, .param_rdata,
    .param_rvalid, .param_rerr, .obj_wr, .obj_rd, .obj_index, .obj_sub, .obj_wdata, .obj_rdata,
    .obj_rvalid, .obj_rerr, .warn_active_raw, .warn_latched_raw, .err_active_raw,
    .err_latched_raw, .warn_active_masked, .warn_latched_masked, .err_active_masked,
    .err_latched_masked, .cycle_time_out, .cycle_time_in, .map_attr, .parameter_error_alarm,
    .network_receive_error_alarm, .sync_error_count);
  fieldbus_master_model i_master (.clk_sys, .req, .good, .sync_event, .pdo_updated);

  // free-running clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, run needs under 150 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic pwr(input logic [7:0] idx, input logic [31:0] d);
    @(negedge clk_sys);
    param_wr = 1'b1;
    param_idx = idx;
    param_wdata = d;
    @(negedge clk_sys);
    param_wr = 1'b0;
  endtask

  task automatic prd(input logic [7:0] idx, input logic [31:0] e, input logic er);
    @(negedge clk_sys);
    param_rd = 1'b1;
    param_idx = idx;
    @(negedge clk_sys);
    param_rd = 1'b0;
    chk({param_rvalid, param_rerr, param_rdata}, {1'b1, er, e});
  endtask

  task automatic owr(input logic [23:0] k, input logic [31:0] d);
    @(negedge clk_sys);
    obj_wr = 1'b1;
    {obj_index, obj_sub} = k;
    obj_wdata = d;
    @(negedge clk_sys);
    obj_wr = 1'b0;
  endtask

  task automatic ord(input logic [23:0] k, input logic [31:0] e, input logic er);
    @(negedge clk_sys);
    obj_rd = 1'b1;
    {obj_index, obj_sub} = k;
    @(negedge clk_sys);
    obj_rd = 1'b0;
    chk({obj_rvalid, obj_rerr, obj_rdata}, {1'b1, er, e});
  endtask

  // one-cycle strobe on init (sel 0) or alarm clear (sel 1)
  task automatic pulse(input logic sel);
    @(negedge clk_sys);
    if (sel) alarm_reset = 1'b1;
    else init_req = 1'b1;
    @(negedge clk_sys);
    alarm_reset = 1'b0;
    init_req = 1'b0;
  endtask

  task automatic ev(input logic g, input logic [15:0] e, input logic al);
    @(negedge clk_sys);
    req = 1'b1;
    good = g;
    @(negedge clk_sys);
    req = 1'b0;
    chk({network_receive_error_alarm, sync_error_count}, {al, e});
  endtask

  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    prd(pidx_mode, mode_rst, 1'b0);
    prd(pidx_limit, {16'h0, limit_rst}, 1'b0);
    prd(pidx_warn, mask_rst, 1'b0);
    prd(pidx_err, mask_rst, 1'b0);
    prd(8'h55, 32'h0, 1'b1);
    chk({cycle_time_out, cycle_time_in}, {cyc_ns_250, cyc_ns_250});
    chk(map_attr, 10'h155);
    owr(okey_warn_mask, 32'h12345678);
    prd(pidx_warn, 32'h12345678, 1'b0);
    pwr(pidx_err, 32'h00ff00ff);
    ord(okey_err_mask, 32'h00ff00ff, 1'b0);
    chk(warn_latched_masked, warn_latched_raw & 32'h12345678);
    chk(err_active_masked, err_active_raw & 32'h00ff00ff);
    ord(okey_err_lat, err_latched_raw & 32'h00ff00ff, 1'b0);
    ord(okey_warn_act, warn_active_raw & 32'h12345678, 1'b0);
    ord(24'h123400, 32'h0, 1'b1);
    // the other direction of each mirror, then the two unread outputs
    pwr(pidx_warn, 32'h0badf00d);
    ord(okey_warn_mask, 32'h0badf00d, 1'b0);
    owr(okey_err_mask, 32'h33cc33cc);
    prd(pidx_err, 32'h33cc33cc, 1'b0);
    chk(warn_active_masked, warn_active_raw & 32'h0badf00d);
    chk(err_latched_masked, err_latched_raw & 32'h33cc33cc);
    // older attribute set and back; mapping may lag the mode word a cycle
    pwr(pidx_mode, 32'h00001000);
    repeat (2) @(negedge clk_sys);
    chk(map_attr, 10'h3aa);
    pwr(pidx_mode, mode_rst);
    repeat (2) @(negedge clk_sys);
    chk(map_attr, 10'h155);
    for (int i = 0; i < 8; i++) begin
      pwr(pidx_cycle, code_tab[i]);
      pulse(1'b0);
      chk({cycle_time_out, cycle_time_in}, {ns_tab[i], ns_tab[i]});
      chk(parameter_error_alarm, 1'b0);
    end
    pwr(pidx_cycle, 32'h3);
    pulse(1'b0);
    chk({parameter_error_alarm, cycle_time_in}, {1'b1, cyc_ns_8m});
    pwr(pidx_cycle, 32'hb);
    @(negedge clk_sys);
    chk(parameter_error_alarm, 1'b1);
    // a master that sets the input cycle object itself
    owr(okey_cycle_in, 32'h000f4240);
    ord(okey_cycle_in, 32'h000f4240, 1'b0);
    chk(cycle_time_in, 32'h000f4240);
    for (int i = 0; i < 9; i++) begin
      ev(i[0], walk[i], i >= 6);
    end
    pulse(1'b1);
    ev(1'b1, 16'h0, 1'b0);
    owr(okey_limit, 32'h4);
    prd(pidx_limit, 32'h4, 1'b0);
    ev(1'b0, 16'h3, 1'b0);
    // a missed event while frozen must not count
    clk_en = 1'b0;
    ev(1'b0, 16'h3, 1'b0);
    clk_en = 1'b1;
    ev(1'b0, 16'h4, 1'b1);
    pwr(pidx_limit, 32'h8000);
    prd(pidx_limit, 32'h4, 1'b0);
    owr(okey_limit, 32'h9000);
    ord(okey_limit, 32'h4, 1'b0);
    pulse(1'b1);
    pwr(pidx_limit, 32'h0);
    ev(1'b0, 16'h0, 1'b0);
    ev(1'b0, 16'h0, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
